// ### common/ppi_pkg.sv
/*
 Shared constants and carrier types for the power path and change-event register bank.
 Assumes a single 125 MHz clock domain and a plain byte-wide register port.
*/
package ppi_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;

	localparam logic [7:0] ADDR_POWER_PATH = 8'h01;
	localparam logic [7:0] ADDR_IRQ        = 8'h02;
	localparam logic [7:0] RESET_POWER_PATH = 8'h3D;
	localparam logic [7:0] RESET_IRQ        = 8'h80;

	// Field positions in power_path_control
	localparam int unsigned POS_AC_SINK    = 7;
	localparam int unsigned POS_USB_SINK   = 6;
	localparam int unsigned POS_AC_PATH    = 5;
	localparam int unsigned POS_USB_PATH   = 4;
	localparam int unsigned POS_AC_LIM_HI  = 3;
	localparam int unsigned POS_AC_LIM_LO  = 2;
	localparam int unsigned POS_USB_LIM_HI = 1;
	localparam int unsigned POS_USB_LIM_LO = 0;

	// Field positions in interrupt_flags_and_masks
	localparam int unsigned POS_RSV_RW     = 7;
	localparam int unsigned POS_BTN_MASK   = 6;
	localparam int unsigned POS_AC_MASK    = 5;
	localparam int unsigned POS_USB_MASK   = 4;
	localparam int unsigned POS_RSV_RO     = 3;
	localparam int unsigned POS_BTN_FLAG   = 2;
	localparam int unsigned POS_AC_FLAG    = 1;
	localparam int unsigned POS_USB_FLAG   = 0;

	// Writable bits of the interrupt register: reserved bit 7 and the three masks
	localparam logic [7:0] IRQ_WR_MASK = 8'hF0;

	// Input-current limit settings in milliamps
	localparam logic [11:0] LIM_100  = 12'h064;
	localparam logic [11:0] LIM_500  = 12'h1F4;
	localparam logic [11:0] LIM_1300 = 12'h514;
	localparam logic [11:0] LIM_1800 = 12'h708;
	localparam logic [11:0] LIM_2500 = 12'h9C4;

	typedef struct packed {
		logic       ac_sink_ctl;
		logic       usb_sink_ctl;
		logic       ac_path_on;
		logic       usb_path_on;
		logic [1:0] ac_current_limit;
		logic [1:0] usb_current_limit;
	} ppi_path_s;

	typedef struct packed {
		logic ac_valid;
		logic usb_valid;
		logic ac_below_det;
		logic usb_below_det;
		logic button_input;
	} ppi_sense_s;

	typedef struct packed {
		logic        ac_sink_on;
		logic        usb_sink_on;
		logic        ac_path_on;
		logic        usb_path_on;
		logic [11:0] ac_limit_ma;
		logic [11:0] usb_limit_ma;
	} ppi_ctrl_s;

endpackage

// ### rtl/ppi_sync.sv
/*
 Two-flop synchroniser for a bus of asynchronous levels.
 Assumes inputs are quasi-static levels; no grouping between bits is kept.
*/
`timescale 1ns/1ps
module ppi_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             ref_clk, // System clock
	input  wire logic             rst_n,   // Asynchronous reset, active low
	input  wire logic [WIDTH-1:0] d,       // Asynchronous levels
	output logic      [WIDTH-1:0] q        // Synchronised levels
);

	logic [WIDTH-1:0] meta;

	// A zero-width bus leaves nothing to synchronise
	if (WIDTH < 1) begin : g_bad_width
		$error("synchroniser width must be at least one");
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule

// ### rtl/ppi_regs.sv
/*
 Power path control and change-event register bank.
 Assumes a byte-wide register port on ref_clk: one-cycle rd_en/wr_en strobes,
 read data registered one cycle after rd_en. Supply sense inputs are asynchronous.
*/
`timescale 1ns/1ps
module ppi_regs
	import ppi_pkg::*;
(
	input  wire logic              ref_clk,     // 125 MHz system clock
	input  wire logic              rst_n,       // Asynchronous reset, active low
	input  wire logic [ADDR_W-1:0] addr,        // Register address
	input  wire logic              wr_en,       // Write strobe, one cycle
	input  wire logic [DATA_W-1:0] wr_data,     // Write data
	input  wire logic              rd_en,       // Read strobe, one cycle
	output logic      [DATA_W-1:0] rd_data,     // Read data, valid cycle after rd_en
	input  wire ppi_sense_s        sense,       // Asynchronous supply and button levels
	output ppi_ctrl_s              ctrl,        // Registered power path controls
	output logic                   irq          // Interrupt request, active high level
);

	//--------------------------------------------------------------
	// Elaboration checks
	//--------------------------------------------------------------
	// The path register is cast straight onto the path struct, and
	// both register offsets must be reachable on the address port
	if ($bits(ppi_path_s) != DATA_W || ADDR_W < 2) begin : g_bad_width
		$error("register port widths do not fit the register map");
	end

	//--------------------------------------------------------------
	// Input synchronisation
	//--------------------------------------------------------------
	ppi_sense_s sense_sync;
	ppi_sense_s sense_prev;

	ppi_sync #(
		.WIDTH ($bits(ppi_sense_s))
	) u_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.d       (sense),
		.q       (sense_sync)
	);

	// Priming gates events only in the first cycle after reset; a nonzero first synchronised value still raises a change event
	logic primed;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sense_prev <= '0;
			primed     <= 1'b0;
		end else begin
			sense_prev <= sense_sync;
			primed     <= 1'b1;
		end
	end

	//--------------------------------------------------------------
	// Address decode
	//--------------------------------------------------------------
	wire sel_path = (addr == ADDR_POWER_PATH);
	wire sel_irq  = (addr == ADDR_IRQ);
	wire wr_path  = wr_en && sel_path;
	wire wr_irq   = wr_en && sel_irq;
	wire rd_irq   = rd_en && sel_irq;

	//--------------------------------------------------------------
	// Registers
	//--------------------------------------------------------------
	logic [7:0] path_reg;
	logic [3:0] irq_hi;
	logic [2:0] flags;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			path_reg <= RESET_POWER_PATH;
		end else if (wr_path) begin
			path_reg <= wr_data;
		end
	end

	// Only bits 7:4 accept writes; flags and bit 3 ignore them
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_hi <= RESET_IRQ[POS_RSV_RW:POS_USB_MASK];
		end else if (wr_irq) begin
			irq_hi <= wr_data[POS_RSV_RW:POS_USB_MASK];
		end
	end

	// Change events from the synchronised levels
	wire btn_evt = primed && (sense_sync.button_input != sense_prev.button_input);
	wire ac_evt  = primed && (sense_sync.ac_valid != sense_prev.ac_valid);
	wire usb_evt = primed && (sense_sync.usb_valid != sense_prev.usb_valid);
	wire [2:0] evt = {btn_evt, ac_evt, usb_evt};

	// A read clears flags, but an event in the same cycle survives the clear
	wire [2:0] next_flags = (rd_irq ? 3'h0 : flags) | evt;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			flags <= 3'h0;
		end else begin
			flags <= next_flags;
		end
	end

	wire [7:0] irq_reg = {irq_hi, 1'b0, flags};

	//--------------------------------------------------------------
	// Read path
	//--------------------------------------------------------------
	wire [7:0] next_rd_data = sel_path ? path_reg :
	                          sel_irq  ? irq_reg  : 8'h00;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= 8'h00;
		end else if (rd_en) begin
			rd_data <= next_rd_data;
		end
	end

	//--------------------------------------------------------------
	// Power path controls
	//--------------------------------------------------------------
	function automatic logic [11:0] lim_ma(input logic [1:0] code, input logic [11:0] top);
		unique case (code)
			2'h0: lim_ma = LIM_100;
			2'h1: lim_ma = LIM_500;
			2'h2: lim_ma = LIM_1300;
			2'h3: lim_ma = top;
		endcase
	endfunction

	ppi_path_s path;
	assign path = ppi_path_s'(path_reg);

	// Mixed sink settings act per bit; the host is expected to avoid them
	wire both_off   = path.ac_sink_ctl && path.usb_sink_ctl;
	wire ac_sink_c  = !path.ac_sink_ctl && sense_sync.usb_valid
	                  && sense_sync.ac_below_det && !both_off;
	wire usb_sink_c = !path.usb_sink_ctl && sense_sync.ac_valid
	                  && sense_sync.usb_below_det && !both_off;

	ppi_ctrl_s next_ctrl;
	assign next_ctrl.ac_sink_on   = ac_sink_c;
	assign next_ctrl.usb_sink_on  = usb_sink_c;
	assign next_ctrl.ac_path_on   = path.ac_path_on;
	assign next_ctrl.usb_path_on  = path.usb_path_on;
	assign next_ctrl.ac_limit_ma  = lim_ma(path.ac_current_limit, LIM_2500);
	assign next_ctrl.usb_limit_ma = lim_ma(path.usb_current_limit, LIM_1800);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= '0;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	//--------------------------------------------------------------
	// Interrupt output
	//--------------------------------------------------------------
	wire [2:0] masks = irq_reg[POS_BTN_MASK:POS_USB_MASK];
	assign irq = |(flags & ~masks);

	//--------------------------------------------------------------
	// Assertions
	//--------------------------------------------------------------
	// Checks on ctrl other than sinks_off_a and path_follow_a wait for primed: ctrl holds zeros until the first edge out of reset
	path_reset_a: assert property (@(posedge ref_clk)
		$rose(rst_n) |-> path_reg == RESET_POWER_PATH)
		else $error("power path register not at reset value");

	irq_reset_a: assert property (@(posedge ref_clk)
		$rose(rst_n) |-> irq_reg == RESET_IRQ)
		else $error("interrupt register not at reset value");

	sinks_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(path_reg[POS_AC_SINK] && path_reg[POS_USB_SINK]) [*2]
		|-> !ctrl.ac_sink_on && !ctrl.usb_sink_on)
		else $error("current sink on while both sink bits set");

	ac_sink_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		primed |-> ctrl.ac_sink_on == $past(!path_reg[POS_AC_SINK]
		&& sense_sync.usb_valid && sense_sync.ac_below_det))
		else $error("adapter sink state wrong");

	usb_sink_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		primed |-> ctrl.usb_sink_on == $past(!path_reg[POS_USB_SINK]
		&& sense_sync.ac_valid && sense_sync.usb_below_det))
		else $error("usb sink state wrong");

	path_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_path |=> ##1 ctrl.ac_path_on == $past(wr_data[POS_AC_PATH], 2)
		&& ctrl.usb_path_on == $past(wr_data[POS_USB_PATH], 2))
		else $error("path enables do not follow register");

	ac_path_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		primed |-> ctrl.ac_path_on == $past(path_reg[POS_AC_PATH]))
		else $error("adapter path enable does not follow register");

	usb_path_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		primed |-> ctrl.usb_path_on == $past(path_reg[POS_USB_PATH]))
		else $error("usb path enable does not follow register");

	ac_lim_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		primed && path_reg[POS_AC_LIM_HI:POS_AC_LIM_LO] == 2'h0
		|=> ctrl.ac_limit_ma == LIM_100)
		else $error("adapter limit not 100 mA");

	ac_lim_mid_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		primed && path_reg[POS_AC_LIM_HI:POS_AC_LIM_LO] == 2'h1
		|=> ctrl.ac_limit_ma == LIM_500)
		else $error("adapter limit not 500 mA");

	ac_lim_high_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		primed && path_reg[POS_AC_LIM_HI:POS_AC_LIM_LO] == 2'h2
		|=> ctrl.ac_limit_ma == LIM_1300)
		else $error("adapter limit not 1300 mA");

	ac_limit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		primed && path_reg[POS_AC_LIM_HI:POS_AC_LIM_LO] == 2'h3
		|=> ctrl.ac_limit_ma == LIM_2500)
		else $error("adapter limit not 2500 mA");

	usb_lim_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		primed && path_reg[POS_USB_LIM_HI:POS_USB_LIM_LO] == 2'h0
		|=> ctrl.usb_limit_ma == LIM_100)
		else $error("usb limit not 100 mA");

	usb_lim_mid_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		primed && path_reg[POS_USB_LIM_HI:POS_USB_LIM_LO] == 2'h1
		|=> ctrl.usb_limit_ma == LIM_500)
		else $error("usb limit not 500 mA");

	usb_lim_high_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		primed && path_reg[POS_USB_LIM_HI:POS_USB_LIM_LO] == 2'h2
		|=> ctrl.usb_limit_ma == LIM_1300)
		else $error("usb limit not 1300 mA");

	usb_limit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		primed && path_reg[POS_USB_LIM_HI:POS_USB_LIM_LO] == 2'h3
		|=> ctrl.usb_limit_ma == LIM_1800)
		else $error("usb limit not 1800 mA");

	btn_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		btn_evt |=> flags[POS_BTN_FLAG])
		else $error("button change not flagged");

	ac_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ac_evt |=> flags[POS_AC_FLAG])
		else $error("adapter change not flagged");

	usb_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		usb_evt |=> flags[POS_USB_FLAG])
		else $error("usb change not flagged");

	flag_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		flags[POS_AC_FLAG] && !rd_irq |=> flags[POS_AC_FLAG])
		else $error("adapter flag lost without read");

	read_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rd_irq && !usb_evt |=> !flags[POS_USB_FLAG])
		else $error("usb flag not cleared by read");

	btn_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rd_irq && !btn_evt |=> !flags[POS_BTN_FLAG])
		else $error("button flag not cleared by read");

	irq_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		irq == ((irq_reg[POS_BTN_FLAG] && !irq_reg[POS_BTN_MASK])
		|| (irq_reg[POS_AC_FLAG] && !irq_reg[POS_AC_MASK])
		|| (irq_reg[POS_USB_FLAG] && !irq_reg[POS_USB_MASK])))
		else $error("interrupt does not follow flags and masks");

	path_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_path |=> path_reg == $past(wr_data))
		else $error("power path write not stored");

	mask_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_irq |=> irq_reg[POS_RSV_RW:POS_USB_MASK] == $past(wr_data[POS_RSV_RW:POS_USB_MASK]))
		else $error("mask write not stored");

	rsv_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!irq_reg[POS_RSV_RO])
		else $error("reserved read-only bit not zero");

	rd_path_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rd_en && sel_path |=> rd_data == $past(path_reg))
		else $error("power path read data wrong");

	rd_irq_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rd_irq |=> rd_data == $past(irq_reg))
		else $error("interrupt register read data wrong");

	ro_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_irq && !rd_irq && flags == 3'h0 && evt == 3'h0
		|=> flags == 3'h0 && !irq_reg[POS_RSV_RO])
		else $error("write altered read-only bits");

endmodule

// ### verif/ppi_host.sv
/*
 Host model for the register port: byte writes and reads.
 Assumes one-cycle strobes on ref_clk and read data one cycle after rd_en.
*/
`timescale 1ns/1ps
module ppi_host
	import ppi_pkg::*;
(
	input  wire logic              ref_clk, // System clock
	output logic      [ADDR_W-1:0] addr,    // Register address
	output logic                   wr_en,   // Write strobe
	output logic      [DATA_W-1:0] wr_data, // Write data
	output logic                   rd_en,   // Read strobe
	input  wire logic [DATA_W-1:0] rd_data  // Read data
);
	initial begin
		addr = 8'h00;
		wr_en = 1'b0;
		wr_data = 8'h00;
		rd_en = 1'b0;
	end

	task automatic write(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == ADDR_IRQ) begin
			v[POS_RSV_RW] = 1'b1;
		end
		if (a == ADDR_POWER_PATH) begin
			v[POS_USB_SINK] = v[POS_AC_SINK];
		end
		@(posedge ref_clk);
		addr <= a;
		wr_data <= v;
		wr_en <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask

	// Data is taken one edge after release, so a slow answer still lands
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		@(posedge ref_clk);
		#1;
		d = rd_data;
	endtask
endmodule

// ### verif/ppi_regs_test.sv
/*
 Self-checking bench for the power path and change-event registers.
 Assumes the host model drives the register port and the bench drives sense.
*/
`timescale 1ns/1ps
module ppi_regs_test
	import ppi_pkg::*;
;
	logic              ref_clk;
	logic              rst_n;
	logic [ADDR_W-1:0] addr;
	logic              wr_en;
	logic [DATA_W-1:0] wr_data;
	logic              rd_en;
	logic [DATA_W-1:0] rd_data;
	ppi_sense_s        sense;
	ppi_ctrl_s         ctrl;
	logic              irq;
	int                n_fail;
	int                check_count;

	ppi_regs ppi_regs_inst (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wr_en(wr_en),
		.wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data), .sense(sense), .ctrl(ctrl),
		.irq(irq));
	ppi_host ppi_host_inst (.ref_clk(ref_clk), .addr(addr), .wr_en(wr_en),
		.wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data));

	// ----------------------------------------
	// Clock, checks and closing
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		ppi_host_inst.read(a, v);
		check({24'h0, v}, {24'h0, exp});
	endtask

	// Flags land three edges after a sense change; five leaves margin
	task automatic set_sense(input ppi_sense_s v);
		@(posedge ref_clk);
		sense <= v;
		repeat (5) @(posedge ref_clk);
		#1;
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		complete_run();
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		logic [11:0] ac_tab [4];
		logic [11:0] usb_tab [4];
		logic [1:0]  k;
		ac_tab = '{LIM_100, LIM_500, LIM_1300, LIM_2500};
		usb_tab = '{LIM_100, LIM_500, LIM_1300, LIM_1800};
		n_fail = 0;
		check_count = 0;
		rst_n = 1'b0;
		sense = '0;
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		check({4'h0, ctrl.ac_path_on, ctrl.usb_path_on}, 32'h3);
		check({ctrl.ac_limit_ma, ctrl.usb_limit_ma}, {LIM_2500, LIM_500});
		rd_chk(ADDR_POWER_PATH, RESET_POWER_PATH);
		rd_chk(ADDR_IRQ, RESET_IRQ);
		ppi_host_inst.write(8'h05, 8'hFF);
		rd_chk(8'h05, 8'h00);
		rd_chk(ADDR_POWER_PATH, RESET_POWER_PATH);
		// Supply sinks and supply change flags
		set_sense('{1'b1, 1'b0, 1'b0, 1'b1, 1'b0});
		check({ctrl.ac_sink_on, ctrl.usb_sink_on, irq}, 32'h3);
		rd_chk(ADDR_IRQ, 8'h82);
		rd_chk(ADDR_IRQ, 8'h80);
		check({31'h0, irq}, 32'h0);
		set_sense('{1'b0, 1'b1, 1'b1, 1'b0, 1'b0});
		check({ctrl.ac_sink_on, ctrl.usb_sink_on}, 32'h2);
		rd_chk(ADDR_IRQ, 8'h83);
		ppi_host_inst.write(ADDR_POWER_PATH, 8'hFD);
		repeat (3) @(posedge ref_clk);
		#1;
		check({ctrl.ac_sink_on, ctrl.usb_sink_on}, 32'h0);
		// Every limit code on both inputs, paths off then on
		ppi_host_inst.write(ADDR_POWER_PATH, 8'h00);
		rd_chk(ADDR_POWER_PATH, 8'h00);
		check({ctrl.ac_path_on, ctrl.usb_path_on}, 32'h0);
		for (int i = 0; i < 4; i++) begin
			k = i[1:0];
			ppi_host_inst.write(ADDR_POWER_PATH, {4'h3, k, k});
			rd_chk(ADDR_POWER_PATH, {4'h3, k, k});
			check({ctrl.ac_limit_ma, ctrl.usb_limit_ma}, {ac_tab[i], usb_tab[i]});
			check({ctrl.ac_path_on, ctrl.usb_path_on}, 32'h3);
		end
		// Masks suppress, flag bits ignore writes
		ppi_host_inst.write(ADDR_IRQ, 8'hFF);
		rd_chk(ADDR_IRQ, 8'hF0);
		set_sense('{1'b1, 1'b0, 1'b1, 1'b0, 1'b1});
		check({31'h0, irq}, 32'h0);
		ppi_host_inst.write(ADDR_IRQ, 8'hF8);
		rd_chk(ADDR_IRQ, 8'hF7);
		ppi_host_inst.write(ADDR_IRQ, 8'h80);
		set_sense('{1'b1, 1'b0, 1'b1, 1'b0, 1'b0});
		check({31'h0, irq}, 32'h1);
		rd_chk(ADDR_IRQ, 8'h84);
		check({31'h0, irq}, 32'h0);
		complete_run();
	end
endmodule
